// file: src/scr_pkg.sv
package scr_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h09;
  localparam logic [7:0] IDX_RESERVED_A = 8'h0A;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h0B;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h0C;
  localparam logic [7:0] IDX_RESERVED_D = 8'h0D;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h0E;
  localparam logic [7:0] IDX_GAIN_HIGH = 8'h0F;

  // reset values
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h10;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
  localparam logic [7:0] RST_GAIN_LOW = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH = 8'h40;

  // system control field positions
  localparam int unsigned MON_MSB = 7;
  localparam int unsigned MON_LSB = 5;
  localparam int unsigned CAL_MSB = 4;
  localparam int unsigned CAL_LSB = 3;
  localparam int unsigned TIMEOUT_BIT = 2;
  localparam int unsigned CRC_BIT = 1;
  localparam int unsigned STATUS_BIT = 0;

  // averaging codes and sample counts
  localparam logic [1:0] CAL_CODE_1 = 2'h0;
  localparam logic [1:0] CAL_CODE_4 = 2'h1;
  localparam logic [1:0] CAL_CODE_8 = 2'h2;
  localparam logic [1:0] CAL_CODE_16 = 2'h3;
  localparam logic [4:0] CAL_SAMPLES_1 = 5'h01;
  localparam logic [4:0] CAL_SAMPLES_4 = 5'h04;
  localparam logic [4:0] CAL_SAMPLES_8 = 5'h08;
  localparam logic [4:0] CAL_SAMPLES_16 = 5'h10;

  // amplifier settings; gain code n means gain 2**n
  localparam logic [1:0] AMP_ENABLE_ON = 2'h1;
  localparam logic [2:0] GAIN_CODE_UNITY = 3'h0;
  localparam logic [2:0] GAIN_CODE_MAX_TEMP = 3'h2;

  // burn-out current level codes
  localparam logic [1:0] BURNOUT_OFF = 2'h0;
  localparam logic [1:0] BURNOUT_0U2 = 2'h1;
  localparam logic [1:0] BURNOUT_1U = 2'h2;
  localparam logic [1:0] BURNOUT_10U = 2'h3;

  typedef enum logic [2:0] {
    MON_OFF = 3'h0,
    MON_MID_SUPPLY = 3'h1,
    MON_TEMPERATURE = 3'h2,
    MON_ANALOG_SUPPLY = 3'h3,
    MON_DIGITAL_SUPPLY = 3'h4,
    MON_BURNOUT_LOW = 3'h5,
    MON_BURNOUT_MID = 3'h6,
    MON_BURNOUT_HIGH = 3'h7
  } scr_monitor_type;

endpackage : scr_pkg

// file: src/scr_monitor_decode.sv
`timescale 1ns/1ps
module scr_monitor_decode (
  input wire logic [2:0] i_monitor_select,
  input wire logic [2:0] i_user_gain,
  input wire logic [1:0] i_amplifier_enable,
  output logic o_inputs_shorted,
  output logic o_temp_sensor_select,
  output logic o_analog_supply_monitor,
  output logic o_digital_supply_monitor,
  output logic o_mux_switches_open,
  output logic [2:0] o_effective_gain,
  output logic o_burnout_enable,
  output logic [1:0] o_burnout_level,
  output logic o_temp_setup_error
);

  scr_pkg::scr_monitor_type mon;

  always_comb begin
    mon = scr_pkg::scr_monitor_type'(i_monitor_select);
    o_inputs_shorted = 1'b0;
    o_temp_sensor_select = 1'b0;
    o_analog_supply_monitor = 1'b0;
    o_digital_supply_monitor = 1'b0;
    o_effective_gain = i_user_gain;
    o_burnout_level = scr_pkg::BURNOUT_OFF;
    case (mon)
      scr_pkg::MON_OFF: begin
        o_inputs_shorted = 1'b0;
      end
      scr_pkg::MON_MID_SUPPLY: begin
        o_inputs_shorted = 1'b1;
      end
      scr_pkg::MON_TEMPERATURE: begin
        o_temp_sensor_select = 1'b1;
      end
      scr_pkg::MON_ANALOG_SUPPLY: begin
        o_analog_supply_monitor = 1'b1;
        o_effective_gain = scr_pkg::GAIN_CODE_UNITY;
      end
      scr_pkg::MON_DIGITAL_SUPPLY: begin
        o_digital_supply_monitor = 1'b1;
        o_effective_gain = scr_pkg::GAIN_CODE_UNITY;
      end
      scr_pkg::MON_BURNOUT_LOW: begin
        o_burnout_level = scr_pkg::BURNOUT_0U2;
      end
      scr_pkg::MON_BURNOUT_MID: begin
        o_burnout_level = scr_pkg::BURNOUT_1U;
      end
      scr_pkg::MON_BURNOUT_HIGH: begin
        o_burnout_level = scr_pkg::BURNOUT_10U;
      end
      default: begin
        o_burnout_level = scr_pkg::BURNOUT_OFF;
      end
    endcase
  end

  assign o_burnout_enable = (o_burnout_level != scr_pkg::BURNOUT_OFF);
  assign o_mux_switches_open = o_inputs_shorted | o_temp_sensor_select | o_analog_supply_monitor
                               | o_digital_supply_monitor;
  // flags a software setup that breaks the temperature sensor limits
  assign o_temp_setup_error = o_temp_sensor_select
                              & ((i_amplifier_enable != scr_pkg::AMP_ENABLE_ON)
                                 | (i_user_gain > scr_pkg::GAIN_CODE_MAX_TEMP));

endmodule : scr_monitor_decode

// file: src/scr_regs.sv
`timescale 1ns/1ps
module scr_regs #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [2:0] i_user_gain,
  input wire logic [1:0] i_amplifier_enable,
  output logic [2:0] o_monitor_select,
  output logic [1:0] o_calibration_average_count,
  output logic [4:0] o_calibration_samples,
  output logic o_timeout_enable,
  output logic o_crc_enable,
  output logic o_status_prefix_enable,
  output logic [15:0] o_offset_correction_value,
  output logic [15:0] o_gain_correction_value,
  output logic o_inputs_shorted,
  output logic o_temp_sensor_select,
  output logic o_analog_supply_monitor,
  output logic o_digital_supply_monitor,
  output logic o_mux_switches_open,
  output logic [2:0] o_effective_gain,
  output logic o_burnout_enable,
  output logic [1:0] o_burnout_level,
  output logic o_temp_setup_error
);

  logic [7:0] system_control;
  logic [7:0] offset_correction_low;
  logic [7:0] offset_correction_high;
  logic [7:0] gain_correction_low;
  logic [7:0] gain_correction_high;
  logic setup_phase;
  logic write_access;
  logic low_lane;
  logic [8:0] access_index;
  logic [7:0] next_read_byte;
  logic next_slverr;

  // returns {mapped, index} for a byte address; mapped needs word alignment and a known index
  function automatic logic [8:0] decode_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx_wide;
    logic [7:0] idx;
    logic mapped;
    idx_wide = addr >> 2;
    idx = idx_wide[7:0];
    mapped = (addr[1:0] == 2'h0) && (idx_wide == ADDR_W'(idx))
             && (idx >= scr_pkg::IDX_SYSTEM_CONTROL) && (idx <= scr_pkg::IDX_GAIN_HIGH);
    return {mapped, idx};
  endfunction : decode_index

  function automatic logic [4:0] samples_of(input logic [1:0] code);
    logic [4:0] n;
    n = scr_pkg::CAL_SAMPLES_8;
    case (code)
      scr_pkg::CAL_CODE_1: n = scr_pkg::CAL_SAMPLES_1;
      scr_pkg::CAL_CODE_4: n = scr_pkg::CAL_SAMPLES_4;
      scr_pkg::CAL_CODE_8: n = scr_pkg::CAL_SAMPLES_8;
      scr_pkg::CAL_CODE_16: n = scr_pkg::CAL_SAMPLES_16;
      default: n = scr_pkg::CAL_SAMPLES_8;
    endcase
    return n;
  endfunction : samples_of

  // zero wait state slave: read data is captured in the setup cycle
  assign o_pready = 1'b1;
  assign setup_phase = i_psel & ~i_penable;
  assign access_index = decode_index(i_paddr);
  assign low_lane = i_pstrb[0];
  assign write_access = i_psel & i_penable & i_pwrite & o_pready & low_lane & access_index[8];

  function automatic logic hit(input logic [8:0] ai, input logic [7:0] idx);
    return ai[8] && (ai[7:0] == idx);
  endfunction : hit

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      system_control <= scr_pkg::RST_SYSTEM_CONTROL;
    end else if (write_access && hit(access_index, scr_pkg::IDX_SYSTEM_CONTROL)) begin
      system_control <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      offset_correction_low <= scr_pkg::RST_OFFSET_LOW;
      offset_correction_high <= scr_pkg::RST_OFFSET_HIGH;
    end else begin
      if (write_access && hit(access_index, scr_pkg::IDX_OFFSET_LOW)) begin
        offset_correction_low <= i_pwdata[7:0];
      end
      if (write_access && hit(access_index, scr_pkg::IDX_OFFSET_HIGH)) begin
        offset_correction_high <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_correction_low <= scr_pkg::RST_GAIN_LOW;
      gain_correction_high <= scr_pkg::RST_GAIN_HIGH;
    end else begin
      if (write_access && hit(access_index, scr_pkg::IDX_GAIN_LOW)) begin
        gain_correction_low <= i_pwdata[7:0];
      end
      if (write_access && hit(access_index, scr_pkg::IDX_GAIN_HIGH)) begin
        gain_correction_high <= i_pwdata[7:0];
      end
    end
  end

  // read mux; reserved registers ignore writes and always read zero
  always_comb begin
    next_read_byte = 8'h00;
    next_slverr = ~access_index[8];
    if (access_index[8]) begin
      case (access_index[7:0])
        scr_pkg::IDX_SYSTEM_CONTROL: next_read_byte = system_control;
        scr_pkg::IDX_RESERVED_A: next_read_byte = scr_pkg::RST_RESERVED;
        scr_pkg::IDX_OFFSET_LOW: next_read_byte = offset_correction_low;
        scr_pkg::IDX_OFFSET_HIGH: next_read_byte = offset_correction_high;
        scr_pkg::IDX_RESERVED_D: next_read_byte = scr_pkg::RST_RESERVED;
        scr_pkg::IDX_GAIN_LOW: next_read_byte = gain_correction_low;
        scr_pkg::IDX_GAIN_HIGH: next_read_byte = gain_correction_high;
        default: next_read_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= {24'h000000, (i_pwrite ? 8'h00 : next_read_byte)};
      o_pslverr <= next_slverr;
    end
  end

  // field views of the system control register, then the 16-bit offset and gain correction values
  assign o_monitor_select = system_control[scr_pkg::MON_MSB:scr_pkg::MON_LSB];
  assign o_calibration_average_count = system_control[scr_pkg::CAL_MSB:scr_pkg::CAL_LSB];
  assign o_calibration_samples = samples_of(o_calibration_average_count);
  assign o_timeout_enable = system_control[scr_pkg::TIMEOUT_BIT];
  assign o_crc_enable = system_control[scr_pkg::CRC_BIT];
  assign o_status_prefix_enable = system_control[scr_pkg::STATUS_BIT];
  assign o_offset_correction_value = {offset_correction_high, offset_correction_low};
  assign o_gain_correction_value = {gain_correction_high, gain_correction_low};

  scr_monitor_decode u_monitor_decode (
    .i_monitor_select(o_monitor_select),
    .i_user_gain(i_user_gain),
    .i_amplifier_enable(i_amplifier_enable),
    .o_inputs_shorted(o_inputs_shorted),
    .o_temp_sensor_select(o_temp_sensor_select),
    .o_analog_supply_monitor(o_analog_supply_monitor),
    .o_digital_supply_monitor(o_digital_supply_monitor),
    .o_mux_switches_open(o_mux_switches_open),
    .o_effective_gain(o_effective_gain),
    .o_burnout_enable(o_burnout_enable),
    .o_burnout_level(o_burnout_level),
    .o_temp_setup_error(o_temp_setup_error)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_setup(logic [ADDR_W-1:0] a, logic wr);
    i_psel && !i_penable && i_pwrite == wr && i_paddr == a;
  endsequence

  sequence s_access(logic [ADDR_W-1:0] a, logic wr);
    i_psel && i_penable && i_pwrite == wr && i_paddr == a;
  endsequence

  localparam logic [ADDR_W-1:0] ADDR_RES_A = ADDR_W'({scr_pkg::IDX_RESERVED_A, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_RES_D = ADDR_W'({scr_pkg::IDX_RESERVED_D, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_SYS = ADDR_W'({scr_pkg::IDX_SYSTEM_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_OFS_L = ADDR_W'({scr_pkg::IDX_OFFSET_LOW, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_GAIN_H = ADDR_W'({scr_pkg::IDX_GAIN_HIGH, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_OFS_H = ADDR_W'({scr_pkg::IDX_OFFSET_HIGH, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_GAIN_L = ADDR_W'({scr_pkg::IDX_GAIN_LOW, 2'b00});

  a_reset_defaults: assert property ($fell(i_rst) |-> system_control == 8'h10
      && o_offset_correction_value == 16'h0000 && o_gain_correction_value == 16'h4000
      && o_calibration_samples == 5'h08)
    else $error("register defaults wrong after reset");

  a_reserved_zero: assert property ((s_setup(ADDR_RES_A, 1'b0) or s_setup(ADDR_RES_D, 1'b0)) ##1
      s_access($past(i_paddr), 1'b0) |-> o_prdata == 32'h00000000 && !o_pslverr)
    else $error("reserved register read is not zero");

  a_sysctl_readback: assert property (s_access(ADDR_SYS, 1'b1) ##0 i_pstrb[0]
      ##1 s_setup(ADDR_SYS, 1'b0) ##1 s_access(ADDR_SYS, 1'b0) |-> o_prdata[7:0] == $past(i_pwdata[7:0], 2))
    else $error("system control readback mismatch");

  a_offset_write: assert property (s_access(ADDR_OFS_L, 1'b1) ##0 i_pstrb[0]
      |=> o_offset_correction_value[7:0] == $past(i_pwdata[7:0]))
    else $error("offset low byte not written");

  a_offset_high: assert property (s_access(ADDR_OFS_H, 1'b1) ##0 i_pstrb[0]
      |=> o_offset_correction_value[15:8] == $past(i_pwdata[7:0]))
    else $error("offset high byte not written");

  a_gain_low_write: assert property (s_access(ADDR_GAIN_L, 1'b1) ##0 i_pstrb[0]
      |=> o_gain_correction_value[7:0] == $past(i_pwdata[7:0]))
    else $error("gain low byte not written");

  a_masked_write: assert property (s_access(ADDR_OFS_L, 1'b1) ##0 !i_pstrb[0]
      |=> $stable(o_offset_correction_value))
    else $error("write with low lane off changed a register");

  a_gain_high_hold: assert property (s_access(ADDR_GAIN_H, 1'b1) ##0 i_pstrb[0] ##1 !write_access [*2]
      |-> o_gain_correction_value[15:8] == $past(i_pwdata[7:0], 2))
    else $error("gain high byte not held");

  a_monitor_reset: assert property ($fell(i_rst) |-> o_monitor_select == 3'h0 && !o_mux_switches_open)
    else $error("monitor not off after reset");

  a_timeout_reset: assert property ($fell(i_rst) |-> !o_timeout_enable)
    else $error("timeout enabled after reset");

  a_crc_reset: assert property ($fell(i_rst) |-> !o_crc_enable)
    else $error("check byte enabled after reset");

  a_status_reset: assert property ($fell(i_rst) |-> !o_status_prefix_enable)
    else $error("status prefix enabled after reset");

  a_unity_gain: assert property (o_monitor_select inside {3'h3, 3'h4} |-> o_effective_gain == 3'h0)
    else $error("supply monitor gain not forced to unity");

  a_user_gain_kept: assert property (o_monitor_select inside {3'h1, 3'h2}
      |-> o_effective_gain == i_user_gain)
    else $error("user gain not kept");

  a_shorted_code: assert property (o_inputs_shorted == (o_monitor_select == 3'h1))
    else $error("input short does not follow monitor code");

  a_temp_select: assert property (o_temp_sensor_select == (o_monitor_select == 3'h2))
    else $error("temperature sensor select does not follow monitor code");

  a_supply_select: assert property (o_analog_supply_monitor == (o_monitor_select == 3'h3)
      && o_digital_supply_monitor == (o_monitor_select == 3'h4))
    else $error("supply monitor select does not follow monitor code");

  a_mux_open: assert property (o_mux_switches_open == (o_monitor_select inside {3'h1, 3'h2, 3'h3, 3'h4}))
    else $error("multiplexer switch state wrong for monitor code");

  a_burnout_level: assert property (o_monitor_select == 3'h7
      |-> o_burnout_enable && o_burnout_level == 2'h3)
    else $error("burn-out level wrong");

  a_burnout_low: assert property (o_monitor_select == 3'h5
      |-> o_burnout_enable && o_burnout_level == 2'h1)
    else $error("burn-out level wrong for lowest setting");

  a_burnout_mid: assert property (o_monitor_select == 3'h6
      |-> o_burnout_enable && o_burnout_level == 2'h2)
    else $error("burn-out level wrong for middle setting");

  a_burnout_off: assert property (o_monitor_select < 3'h5
      |-> !o_burnout_enable && o_burnout_level == 2'h0)
    else $error("burn-out source on outside burn-out codes");

  a_cal_samples: assert property (o_calibration_average_count == 2'h3 |-> o_calibration_samples == 5'h10)
    else $error("calibration count wrong");

  a_cal_one: assert property (o_calibration_average_count == 2'h0 |-> o_calibration_samples == 5'h01)
    else $error("calibration count wrong for one sample");

  a_cal_four: assert property (o_calibration_average_count == 2'h1 |-> o_calibration_samples == 5'h04)
    else $error("calibration count wrong for four samples");

  a_cal_eight: assert property (o_calibration_average_count == 2'h2 |-> o_calibration_samples == 5'h08)
    else $error("calibration count wrong for eight samples");

  a_temp_error: assert property (o_monitor_select == 3'h2 && i_amplifier_enable != 2'h1
      |-> o_temp_setup_error)
    else $error("temperature setup error not flagged");

  a_temp_gain_limit: assert property (o_monitor_select == 3'h2 && i_user_gain > 3'h2
      |-> o_temp_setup_error)
    else $error("temperature gain above limit not flagged");

  a_temp_setup_ok: assert property (o_monitor_select == 3'h2 && i_amplifier_enable == 2'h1
      && i_user_gain <= 3'h2 |-> !o_temp_setup_error)
    else $error("valid temperature setup flagged");

  a_flag_bits: assert property (o_timeout_enable == system_control[2]
      && o_crc_enable == system_control[1] && o_status_prefix_enable == system_control[0])
    else $error("enable bits do not follow register");

  a_unmapped_error: assert property (i_psel && i_penable && !access_index[8] |-> o_pslverr)
    else $error("unmapped access without error response");

endmodule : scr_regs

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [3:0] i_pstrb = 4'hF;
  logic [2:0] i_user_gain = 3'h0;
  logic [1:0] i_amplifier_enable = 2'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_timeout_enable, o_crc_enable, o_status_prefix_enable;
  logic [2:0] o_monitor_select, o_effective_gain;
  logic [1:0] o_calibration_average_count, o_burnout_level;
  logic [4:0] o_calibration_samples;
  logic [15:0] o_offset_correction_value, o_gain_correction_value;
  logic o_inputs_shorted, o_temp_sensor_select, o_analog_supply_monitor, o_digital_supply_monitor;
  logic o_mux_switches_open, o_burnout_enable, o_temp_setup_error;
  // bit 33 masks read data, bit 32 is the expected error flag
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] rng = 32'h00000022;
  logic [7:0] rst_val [7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  logic [7:0] shadow [7];

  scr_regs #(.ADDR_W(12)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_user_gain(i_user_gain),
    .i_amplifier_enable(i_amplifier_enable), .o_monitor_select(o_monitor_select),
    .o_calibration_average_count(o_calibration_average_count), .o_calibration_samples(o_calibration_samples),
    .o_timeout_enable(o_timeout_enable), .o_crc_enable(o_crc_enable),
    .o_status_prefix_enable(o_status_prefix_enable), .o_offset_correction_value(o_offset_correction_value),
    .o_gain_correction_value(o_gain_correction_value), .o_inputs_shorted(o_inputs_shorted),
    .o_temp_sensor_select(o_temp_sensor_select), .o_analog_supply_monitor(o_analog_supply_monitor),
    .o_digital_supply_monitor(o_digital_supply_monitor), .o_mux_switches_open(o_mux_switches_open),
    .o_effective_gain(o_effective_gain), .o_burnout_enable(o_burnout_enable),
    .o_burnout_level(o_burnout_level), .o_temp_setup_error(o_temp_setup_error));

  always #50 i_clk = ~i_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : ba

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("counts: tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // called right after a rising edge; leaves psel and penable high for a following setup or idle to lower
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb,
                     input logic [33:0] exp);
    int n;
    exp_q.push_back(exp);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= data;
    i_pstrb <= strb;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask : apb

  task automatic idle;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask : idle

  task automatic read_all;
    for (int r = 0; r < 7; r++) begin
      apb(1'b0, ba(8'h09 + 8'(r)), 32'h0, 4'h0, {2'b00, 24'h0, shadow[r]});
    end
    idle();
  endtask : read_all

  task automatic chk_decode(input logic [2:0] m, input logic [2:0] g, input logic [1:0] a);
    logic [11:0] e;
    e = {m == 3'h1, m == 3'h2, m == 3'h3, m == 3'h4, m >= 3'h1 && m <= 3'h4,
         (m == 3'h3 || m == 3'h4) ? 3'h0 : g, m >= 3'h5, (m >= 3'h5) ? 2'(m - 3'h4) : 2'h0,
         m == 3'h2 && (a != 2'h1 || g > 3'h2)};
    chk({21'h0, o_inputs_shorted, o_temp_sensor_select, o_analog_supply_monitor, o_digital_supply_monitor,
         o_mux_switches_open, o_effective_gain, o_burnout_enable, o_burnout_level, o_temp_setup_error},
        {21'h0, e});
  endtask : chk_decode

  // result watcher: each completed access is judged against the oldest note
  always @(posedge i_clk) begin
    if (i_psel === 1'b1 && i_penable === 1'b1 && o_pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("ERROR t=%0t got=%h exp=%h", $time, o_prdata, 32'h0);
      end else begin
        mon_e = exp_q.pop_front();
        if (mon_e[33]) begin
          chk({o_pslverr, 32'h0}, {mon_e[32], 32'h0});
        end else begin
          chk({o_pslverr, o_prdata}, mon_e[32:0]);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    shadow = rst_val;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    read_all();
    $display("test reset_defaults done");
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 7; r++) begin
        rng = xs(rng);
        apb(1'b1, ba(8'h09 + 8'(r)), (r == 1 || r == 4) ? 32'h0 : rng, 4'hF, 34'h0);
        if (r != 1 && r != 4) shadow[r] = rng[7:0];
        apb(1'b0, ba(8'h09 + 8'(r)), 32'h0, 4'h0, {2'b00, 24'h0, shadow[r]});
      end
      idle();
      #1;
      chk({1'h0, o_offset_correction_value, o_gain_correction_value},
          {1'h0, shadow[3], shadow[2], shadow[6], shadow[5]});
      chk({25'h0, o_monitor_select, o_calibration_average_count, o_timeout_enable, o_crc_enable,
           o_status_prefix_enable}, {25'h0, shadow[0]});
      @(posedge i_clk);
    end
    $display("test random_readback done");
    apb(1'b1, ba(8'h0B), 32'h000000A5, 4'hE, 34'h0);
    apb(1'b0, ba(8'h0B), 32'h0, 4'h0, {2'b00, 24'h0, shadow[2]});
    apb(1'b1, 12'h040, 32'h000000FF, 4'hF, {2'b11, 32'h0});
    apb(1'b0, 12'h040, 32'h0, 4'h0, {2'b11, 32'h0});
    apb(1'b0, 12'h02D, 32'h0, 4'h0, {2'b11, 32'h0});
    apb(1'b0, 12'h020, 32'h0, 4'h0, {2'b11, 32'h0});
    idle();
    read_all();
    $display("test refusals done");
    for (int m = 0; m < 16; m++) begin
      rng = xs(rng);
      i_user_gain <= rng[2:0];
      i_amplifier_enable <= rng[4:3];
      shadow[0] = {3'(m), 2'(m), rng[7:5]};
      apb(1'b1, ba(8'h09), {24'h0, shadow[0]}, 4'hF, 34'h0);
      idle();
      #1;
      chk_decode(3'(m), rng[2:0], rng[4:3]);
      chk({28'h0, o_calibration_samples},
          {28'h0, (m[1:0] == 2'h0) ? 5'h01 : 5'h01 << (3'(m[1:0]) + 3'h1)});
      @(posedge i_clk);
    end
    $display("test monitor_codes done");
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    shadow = rst_val;
    read_all();
    $display("test second_reset done");
    repeat (2) @(posedge i_clk);
    if (exp_q.size() != 0) n_mismatch++;
    close_out();
  end
endmodule : tb_top
